/* pci_clock_run_power_manager.sv */
// Purpose: Bus clock stop/restart, card clock stop, card power-down, suspend and ring/wake routing.
// Assumes: Pins pass two flip-flops; busy flags come from logic on sys_clk_i.
// Notes: The bus clock is sampled as a plain input and its edges found here.
//
// What this block does
// - Hold-bus-clock or keep-bus-clock bit set: refuse to let bus clock stop.
// - Card resource, card master or posted card data busy: keep bus clock.
// - Pending interrupts or card clock still running: refuse bus clock stop.
// - Serial-bus managers busy, posted, interrogation or bus not idle: keep bus clock.
// - Card interrupt, status-change, wake or ring event restarts a stopped bus clock.
// - Card clock-run start attempt or card bus request restarts the bus clock.
// - Twisted pair activation, FIFO data, master busy, interrupts or hold bit restart.
// - Clock-run signalling only works when terminal six carries that function.
// - Stop the card clock after card inactivity, using the card clock-run handshake.
// - Output-disable bit floats the card interface and resets the card.
// - Auto power-down floats the card while inactive, without reset.
// - Suspend blocks both reset inputs and gates the internal bus clock.
// - Suspend floats bus outputs and gates clock unless bus grant is asserted.
// - Registers keep their contents when a reset arrives during suspend.
// - Ring and multifunction outputs keep working during suspend unless disabled.
// - Status-change and ring paths need no bus clock; serial interrupts need restart.
// - Card ring reaches the ring output only with ring-forward enable and power.
// - Card wake reaches the ring output under the status-change mask bit.
// - Ring function enabled by its enable bit, wake signal by its enable bit.
// - Routing select zero: one shared terminal, ring wins when both enabled.
`timescale 1ns/1ps
`include "clk_power_defs.svh"

module pci_clock_run_power_manager (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Host bus pins
  input wire logic pci_clk_i,
  input wire logic clkrun_n_i,
  output logic clkrun_n_o,
  output logic clkrun_oe_o,
  input wire logic bus_grant_i,
  input wire logic host_bus_reset_i,
  input wire logic global_reset_input_i,
  input wire logic suspend_i,
  output logic pci_out_float_o,
  output logic pci_clk_gate_o,
  output logic core_reset_o,
  // Card pins
  input wire logic cclkrun_n_i,
  output logic cclkrun_oe_o,
  output logic card_clk_en_o,
  input wire logic card_req_i,
  input wire logic card_ireq_i,
  input wire logic card_cint_i,
  input wire logic card_stschg_i,
  input wire logic card_wake_event_i,
  input wire logic card_ring_i,
  input wire logic card_powered_i,
  output logic card_hiz_o,
  output logic card_reset_o,
  // Serial bus pin
  input wire logic tp_active_i,
  // Internal activity flags
  input wire logic card16_busy_i,
  input wire logic card_master_busy_i,
  input wire logic card_posted_i,
  input wire logic int_pending_i,
  input wire logic serial_res_busy_i,
  input wire logic serial_master_busy_i,
  input wire logic serial_posted_i,
  input wire logic interrogation_i,
  input wire logic serial_not_idle_i,
  input wire logic fifo_data_i,
  input wire logic card16_active_i,
  input wire logic card_bus_active_i,
  input wire logic pme_event_i,
  // Wake terminals
  output logic ring_wake_output_o,
  output logic multifunction_terminal_two_o,
  output logic multifunction_terminal_four_o
);
  import clk_power_pkg::*;

  pm_state_t st;
  pm_state_t next_st;
  logic [`PIN_COUNT-1:0] pins;

  assign pins = {bus_grant_i, global_reset_input_i, host_bus_reset_i, suspend_i, tp_active_i,
                 card_ring_i, card_wake_event_i, card_stschg_i, card_cint_i, card_ireq_i,
                 card_req_i, cclkrun_n_i, clkrun_n_i, pci_clk_i};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [`PIN_COUNT-1:0] s;
    logic pclk_rise;
    logic keep;
    logic wake;
    logic suspend;
    logic reg_clear;
    logic ring_evt;
    logic pme_evt;
    s = st.sync2;
    pclk_rise = 1'b0;
    keep = 1'b0;
    wake = 1'b0;
    suspend = 1'b0;
    reg_clear = 1'b0;
    ring_evt = 1'b0;
    pme_evt = 1'b0;
    next_st = st;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.pclk_prev = s[`PIN_PCLK];
    next_st.tp_prev = s[`PIN_TP_ACTIVE];
    pclk_rise = s[`PIN_PCLK] & ~st.pclk_prev;
    suspend = s[`PIN_SUSPEND];

    // Bus clock presence: silent for the stop window means stopped
    if (pclk_rise) begin
      next_st.stop_cnt = 5'h00;
      next_st.pclk_stopped = 1'b0;
    end else if (st.stop_cnt == 5'(`PCLK_STOP_CYC - 1)) begin
      next_st.pclk_stopped = 1'b1;
    end else begin
      next_st.stop_cnt = st.stop_cnt + 5'h01;
    end

    keep = st.hold_bus_clock_bit | st.keep_pclk
         | card16_busy_i | card_master_busy_i | card_posted_i
         | int_pending_i | (st.cc != CC_STOPPED)
         | serial_res_busy_i | serial_master_busy_i | serial_posted_i
         | interrogation_i | serial_not_idle_i;
    // Status-change events restart the clock so a serial interrupt can be sent
    wake = s[`PIN_IREQ] | s[`PIN_CINT] | s[`PIN_STSCHG] | s[`PIN_WAKE] | s[`PIN_RING]
         | ~s[`PIN_CCLKRUN_N] | s[`PIN_CREQ]
         | (s[`PIN_TP_ACTIVE] & ~st.tp_prev) | fifo_data_i | serial_master_busy_i
         | card_master_busy_i | int_pending_i | st.hold_bus_clock_bit;

    // ****************************************
    // Bus clock-run handshake
    // ****************************************
    next_st.clkrun_n = 1'b0;
    unique case (st.ck)
      CK_RUN: begin
        next_st.clkrun_oe = 1'b0;
        next_st.edge_cnt = 2'h0;
        if (s[`PIN_CLKRUN_N] && keep && st.mf6_clkrun) begin
          next_st.ck = CK_KEEP;
          next_st.clkrun_oe = 1'b1;
        end else if (st.pclk_stopped) begin
          next_st.ck = CK_STOPPED;
        end
      end
      CK_KEEP: begin
        if (pclk_rise) begin
          next_st.edge_cnt = st.edge_cnt + 2'h1;
        end
        if (st.edge_cnt == 2'(`PCLK_HOLD_EDGES)) begin
          next_st.ck = CK_RUN;
          next_st.clkrun_oe = 1'b0;
        end
      end
      CK_STOPPED: begin
        next_st.edge_cnt = 2'h0;
        if (pclk_rise) begin
          next_st.ck = CK_RUN;
        end else if (wake && st.mf6_clkrun) begin
          next_st.ck = CK_RESTART;
          next_st.clkrun_oe = 1'b1;
        end
      end
      CK_RESTART: begin
        // Held until the clock has really resumed, not just for a fixed time
        if (pclk_rise) begin
          next_st.edge_cnt = st.edge_cnt + 2'h1;
        end
        if (st.edge_cnt == 2'(`PCLK_HOLD_EDGES) || !st.mf6_clkrun) begin
          next_st.ck = CK_RUN;
          next_st.clkrun_oe = 1'b0;
        end
      end
    endcase

    // ****************************************
    // Card clock manager
    // ****************************************
    unique case (st.cc)
      CC_RUN: begin
        next_st.cclkrun_oe = 1'b1;
        next_st.card_clk_en = 1'b1;
        next_st.ask_cnt = 4'h0;
        if (card_bus_active_i || s[`PIN_CREQ]) begin
          next_st.idle_cnt = 7'h00;
        end else if (st.idle_cnt == 7'(`CARD_IDLE_CYC - 1)) begin
          next_st.cc = CC_ASK;
          next_st.cclkrun_oe = 1'b0;
          next_st.idle_cnt = 7'h00;
        end else begin
          next_st.idle_cnt = st.idle_cnt + 7'h01;
        end
      end
      CC_ASK: begin
        next_st.ask_cnt = st.ask_cnt + 4'h1;
        // Our own drive takes the synchroniser delay to leave the sampled pin
        if (st.ask_cnt >= 4'(`CARD_ASK_SETTLE) && !s[`PIN_CCLKRUN_N]) begin
          next_st.cc = CC_RUN;
          next_st.cclkrun_oe = 1'b1;
        end else if (st.ask_cnt == 4'(`CARD_ASK_SETTLE + `CARD_ASK_CYC)) begin
          next_st.cc = CC_STOPPED;
          next_st.card_clk_en = 1'b0;
        end
      end
      CC_STOPPED: begin
        if (!s[`PIN_CCLKRUN_N] || s[`PIN_CREQ]) begin
          next_st.cc = CC_RUN;
          next_st.cclkrun_oe = 1'b1;
          next_st.card_clk_en = 1'b1;
        end
      end
      default: begin
        next_st.cc = CC_RUN;
      end
    endcase

    // ****************************************
    // Sixteen-bit card power-down
    // ****************************************
    next_st.card_hiz = st.card_output_disable_bit
                     | (st.auto_power_down_bit & ~card16_active_i);
    if (st.rst_cnt != 5'h00) begin
      next_st.rst_cnt = st.rst_cnt - 5'h01;
    end
    next_st.card_rst = (st.rst_cnt != 5'h00);

    // ****************************************
    // Suspend
    // ****************************************
    next_st.core_rst = (s[`PIN_HOST_RST] | s[`PIN_GLOBAL_RST]) & ~suspend;
    // Arbiter must not park here while floating; a parked grant would keep clock
    next_st.pci_float = suspend & ~s[`PIN_GNT];
    next_st.pclk_gate = suspend & ~s[`PIN_GNT];
    reg_clear = next_st.core_rst;

    // ****************************************
    // Ring and wake routing, never gated by suspend
    // ****************************************
    ring_evt = (s[`PIN_RING] & card_powered_i & st.ring_forward_enable)
             | (s[`PIN_WAKE] & st.status_change_mask_bit);
    pme_evt = pme_event_i & st.pme_enable;
    if (!st.ring_route) begin
      // Shared terminal: an enabled ring function hides wake entirely
      next_st.ri_pme_term = st.ring_function_enable ? ring_evt : pme_evt;
      next_st.mf2 = 1'b0;
      next_st.mf4 = 1'b0;
    end else begin
      next_st.ri_pme_term = pme_evt;
      next_st.mf2 = st.ring_function_enable & ring_evt & ~st.ring_term_sel;
      next_st.mf4 = st.ring_function_enable & ring_evt & st.ring_term_sel;
    end

    // ****************************************
    // Register port
    // ****************************************
    next_st.rdata = 16'h0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `OFS_SYS_CTRL: begin
          next_st.rdata[`SYS_RING_ROUTE_BIT] = st.ring_route;
          next_st.rdata[`SYS_HOLD_CLK_BIT] = st.hold_bus_clock_bit;
          next_st.rdata[`SYS_MF6_CLKRUN_BIT] = st.mf6_clkrun;
          next_st.rdata[`SYS_RING_TERM_BIT] = st.ring_term_sel;
        end
        `OFS_MISC_CFG: next_st.rdata[`MISC_KEEP_PCLK_BIT] = st.keep_pclk;
        `OFS_PWR_CTRL: next_st.rdata[`PWR_OUT_DISABLE_BIT] = st.card_output_disable_bit;
        `OFS_INT_GEN_CTRL: next_st.rdata[`INT_RING_FWD_BIT] = st.ring_forward_enable;
        `OFS_GLOBAL_CTRL: next_st.rdata[`GLB_AUTO_PD_BIT] = st.auto_power_down_bit;
        `OFS_SOCKET_MASK: next_st.rdata[`SOCK_CSC_MASK_BIT] = st.status_change_mask_bit;
        `OFS_CARD_CTRL: next_st.rdata[`CARD_RING_EN_BIT] = st.ring_function_enable;
        `OFS_PM_CSR: next_st.rdata[`PM_PME_EN_BIT] = st.pme_enable;
        `OFS_STATUS: next_st.rdata = {7'h00, suspend, st.card_hiz, st.pclk_stopped,
                                      keep, 1'(st.cc), 1'(st.cc >> 1), 1'(st.ck), 1'(st.ck >> 1), 1'b0};
        default: next_st.rdata = 16'h0000;
      endcase
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `OFS_SYS_CTRL: begin
          next_st.ring_route = reg_wdata_i[`SYS_RING_ROUTE_BIT];
          next_st.hold_bus_clock_bit = reg_wdata_i[`SYS_HOLD_CLK_BIT];
          next_st.mf6_clkrun = reg_wdata_i[`SYS_MF6_CLKRUN_BIT];
          next_st.ring_term_sel = reg_wdata_i[`SYS_RING_TERM_BIT];
        end
        `OFS_MISC_CFG: next_st.keep_pclk = reg_wdata_i[`MISC_KEEP_PCLK_BIT];
        `OFS_PWR_CTRL: begin
          next_st.card_output_disable_bit = reg_wdata_i[`PWR_OUT_DISABLE_BIT];
          if (reg_wdata_i[`PWR_OUT_DISABLE_BIT] && !st.card_output_disable_bit) begin
            next_st.rst_cnt = 5'(`CARD_RST_CYC);
          end
        end
        `OFS_INT_GEN_CTRL: next_st.ring_forward_enable = reg_wdata_i[`INT_RING_FWD_BIT];
        `OFS_GLOBAL_CTRL: next_st.auto_power_down_bit = reg_wdata_i[`GLB_AUTO_PD_BIT];
        `OFS_SOCKET_MASK: next_st.status_change_mask_bit = reg_wdata_i[`SOCK_CSC_MASK_BIT];
        `OFS_CARD_CTRL: next_st.ring_function_enable = reg_wdata_i[`CARD_RING_EN_BIT];
        `OFS_PM_CSR: next_st.pme_enable = reg_wdata_i[`PM_PME_EN_BIT];
        default: begin
        end
      endcase
    end
    // Only an unsuspended reset clears software state
    if (reg_clear) begin
      next_st.ring_route = `REG_RESET_VAL;
      next_st.hold_bus_clock_bit = `REG_RESET_VAL;
      next_st.mf6_clkrun = `REG_RESET_VAL;
      next_st.ring_term_sel = `REG_RESET_VAL;
      next_st.keep_pclk = `REG_RESET_VAL;
      next_st.card_output_disable_bit = `REG_RESET_VAL;
      next_st.ring_forward_enable = `REG_RESET_VAL;
      next_st.auto_power_down_bit = `REG_RESET_VAL;
      next_st.status_change_mask_bit = `REG_RESET_VAL;
      next_st.ring_function_enable = `REG_RESET_VAL;
      next_st.pme_enable = `REG_RESET_VAL;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o = st.rdata;
  assign clkrun_n_o = st.clkrun_n;
  assign clkrun_oe_o = st.clkrun_oe;
  assign pci_out_float_o = st.pci_float;
  assign pci_clk_gate_o = st.pclk_gate;
  assign core_reset_o = st.core_rst;
  assign cclkrun_oe_o = st.cclkrun_oe;
  assign card_clk_en_o = st.card_clk_en;
  assign card_hiz_o = st.card_hiz;
  assign card_reset_o = st.card_rst;
  assign ring_wake_output_o = st.ri_pme_term;
  assign multifunction_terminal_two_o = st.mf2;
  assign multifunction_terminal_four_o = st.mf4;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  hold_blocks_stop_a: assert property ((st.ck == CK_RUN) && st.mf6_clkrun && st.hold_bus_clock_bit
    |=> st.ck != CK_STOPPED)
    else $error("bus clock stopped while hold bit set");
  busy_blocks_stop_a: assert property ((st.ck == CK_RUN) && st.mf6_clkrun && card16_busy_i
    |=> st.ck != CK_STOPPED)
    else $error("bus clock stopped while card resource busy");
  cclk_blocks_stop_a: assert property ((st.ck == CK_RUN) && st.mf6_clkrun && (st.cc != CC_STOPPED)
    |=> st.ck != CK_STOPPED)
    else $error("bus clock stopped while card clock runs");
  serial_blocks_stop_a: assert property ((st.ck == CK_RUN) && st.mf6_clkrun && serial_not_idle_i
    |=> st.ck != CK_STOPPED)
    else $error("bus clock stopped while serial bus active");
  irq_restart_a: assert property ((st.ck == CK_STOPPED) && st.mf6_clkrun && st.sync2[`PIN_IREQ]
    && !(st.sync2[`PIN_PCLK] && !st.pclk_prev) |=> clkrun_oe_o && (st.ck == CK_RESTART))
    else $error("card interrupt did not restart bus clock");
  unrouted_quiet_a: assert property (!st.mf6_clkrun && !clkrun_oe_o |=> !clkrun_oe_o)
    else $error("clock-run driven without terminal routing");
  restart_held_a: assert property ($rose(clkrun_oe_o) && (st.ck == CK_RESTART) && st.mf6_clkrun
    |-> clkrun_oe_o throughout (st.ck == CK_RESTART)[*2])
    else $error("restart request released too early");
  coe_float_a: assert property (st.card_output_disable_bit |=> card_hiz_o)
    else $error("output disable did not float card");
  coe_reset_a: assert property ($rose(st.card_output_disable_bit) |=> card_reset_o ##1 card_reset_o)
    else $error("output disable did not reset card");
  apd_float_a: assert property (st.auto_power_down_bit && !card16_active_i |=> card_hiz_o)
    else $error("auto power-down did not float idle card");
  suspend_float_a: assert property (st.sync2[`PIN_SUSPEND] && !st.sync2[`PIN_GNT] |=> pci_out_float_o
    && pci_clk_gate_o && !core_reset_o)
    else $error("suspend did not float bus outputs");
  ring_mask_a: assert property (!st.ring_route && st.ring_function_enable && !st.ring_forward_enable
    && !st.status_change_mask_bit |=> !ring_wake_output_o)
    else $error("ring forwarded without enable");
  shared_ring_wins_a: assert property (!st.ring_route && st.ring_function_enable && st.pme_enable
    && pme_event_i && !st.sync2[`PIN_RING] && !st.sync2[`PIN_WAKE] |=> !ring_wake_output_o)
    else $error("wake seen on shared terminal with ring enabled");

endmodule : pci_clock_run_power_manager

/* clk_power_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the clock-run power manager.
// Assumes: System clock of 20 MHz.
// Notes: Register offsets are word indices on the plain register port.
`ifndef CLK_POWER_DEFS_SVH
`define CLK_POWER_DEFS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define SYS_CLK_MHZ 20
// Least times round up to whole cycles
`define PCLK_STOP_NS 800
`define PCLK_STOP_CYC (((`PCLK_STOP_NS * `SYS_CLK_MHZ) + 999) / 1000)
`define CARD_IDLE_NS 3200
`define CARD_IDLE_CYC (((`CARD_IDLE_NS * `SYS_CLK_MHZ) + 999) / 1000)
`define CARD_ASK_NS 400
`define CARD_ASK_CYC (((`CARD_ASK_NS * `SYS_CLK_MHZ) + 999) / 1000)
`define CARD_ASK_SETTLE 3
`define CARD_RST_NS 1000
`define CARD_RST_CYC (((`CARD_RST_NS * `SYS_CLK_MHZ) + 999) / 1000)
`define PCLK_HOLD_EDGES 2

// ****************************************
// Register offsets
// ****************************************
`define OFS_SYS_CTRL 4'h0
`define OFS_MISC_CFG 4'h1
`define OFS_PWR_CTRL 4'h2
`define OFS_INT_GEN_CTRL 4'h3
`define OFS_GLOBAL_CTRL 4'h4
`define OFS_SOCKET_MASK 4'h5
`define OFS_CARD_CTRL 4'h6
`define OFS_PM_CSR 4'h7
`define OFS_STATUS 4'h8

// ****************************************
// Field positions
// ****************************************
`define SYS_RING_ROUTE_BIT 0
`define SYS_HOLD_CLK_BIT 1
`define SYS_MF6_CLKRUN_BIT 2
`define SYS_RING_TERM_BIT 3
`define MISC_KEEP_PCLK_BIT 0
`define PWR_OUT_DISABLE_BIT 7
`define INT_RING_FWD_BIT 7
`define GLB_AUTO_PD_BIT 0
`define SOCK_CSC_MASK_BIT 0
`define CARD_RING_EN_BIT 7
`define PM_PME_EN_BIT 8
`define REG_RESET_VAL 1'b0

// ****************************************
// Synchronised pin positions
// ****************************************
`define PIN_COUNT 14
`define PIN_PCLK 0
`define PIN_CLKRUN_N 1
`define PIN_CCLKRUN_N 2
`define PIN_CREQ 3
`define PIN_IREQ 4
`define PIN_CINT 5
`define PIN_STSCHG 6
`define PIN_WAKE 7
`define PIN_RING 8
`define PIN_TP_ACTIVE 9
`define PIN_SUSPEND 10
`define PIN_HOST_RST 11
`define PIN_GLOBAL_RST 12
`define PIN_GNT 13

`endif

/* clk_power_pkg.sv */
// Purpose: Types of the clock-run power manager.
// Assumes: Constants come from clk_power_defs.svh.
// Notes: The whole module state is one packed struct.
`include "clk_power_defs.svh"

package clk_power_pkg;

  typedef enum logic [1:0] {CK_RUN, CK_KEEP, CK_STOPPED, CK_RESTART} pclk_state_t;
  typedef enum logic [1:0] {CC_RUN, CC_ASK, CC_STOPPED} cclk_state_t;

  typedef struct packed {
    logic [`PIN_COUNT-1:0] sync1;
    logic [`PIN_COUNT-1:0] sync2;
    logic pclk_prev;
    logic tp_prev;
    logic [4:0] stop_cnt;
    logic pclk_stopped;
    pclk_state_t ck;
    logic [1:0] edge_cnt;
    cclk_state_t cc;
    logic [6:0] idle_cnt;
    logic [3:0] ask_cnt;
    logic [4:0] rst_cnt;
    logic ring_route;
    logic hold_bus_clock_bit;
    logic mf6_clkrun;
    logic ring_term_sel;
    logic keep_pclk;
    logic card_output_disable_bit;
    logic ring_forward_enable;
    logic auto_power_down_bit;
    logic status_change_mask_bit;
    logic ring_function_enable;
    logic pme_enable;
    logic [15:0] rdata;
    logic clkrun_n;
    logic clkrun_oe;
    logic cclkrun_oe;
    logic card_clk_en;
    logic card_hiz;
    logic card_rst;
    logic core_rst;
    logic pci_float;
    logic pclk_gate;
    logic ri_pme_term;
    logic mf2;
    logic mf4;
  } pm_state_t;

endpackage : clk_power_pkg

/* bus_clock_model.sv */
// Purpose: Central clock resource that owns the bus clock and the clock-run line.
// Assumes: The clock-run line is pulled up whenever no party drives it low.
// Notes: It stops the clock after four quiet clocks and restarts only when the block pulls the line.
`timescale 1ns/1ps
module bus_clock_model (
  // Bench control
  input wire logic stop_req_i,
  // Block side
  input wire logic dev_oe_i,
  input wire logic dev_n_i,
  output logic pci_clk_o,
  output logic clkrun_n_o,
  output logic running_o
);
  int quiet;
  // Released while stopping or stopped, so the pull-up shows high
  assign clkrun_n_o = (dev_oe_i && !dev_n_i) ? 1'b0 : !(running_o && !stop_req_i);
  initial begin
    pci_clk_o = 1'b0;
    running_o = 1'b1;
    quiet = 0;
    forever begin
      #200;
      if (!clkrun_n_o) quiet = 0;
      if (dev_oe_i) running_o = 1'b1;
      if (running_o) pci_clk_o = !pci_clk_o;
      if (pci_clk_o && stop_req_i && clkrun_n_o) quiet++;
      // Clock stands low while stopped
      if (quiet >= 4 && !pci_clk_o) running_o = 1'b0;
    end
  end
endmodule : bus_clock_model

/* tb.sv */
// Purpose: Self-checking bench of the clock-run power manager.
// Assumes: The bus clock model drives the clock pin and the clock-run line.
// Notes: Single-bit inputs sit in one vector so that loops can pick them.
`timescale 1ns/1ps
module tb;
  localparam int KEEP [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 15, 19};
  localparam int WAKE [10] = '{11, 12, 13, 14, 15, 16, 10, 9, 1, 3};
  logic sys_clk_i, srst_i, reg_wr_i, reg_rd_i, stop_req, running, pci_clk_i, clkrun_n_i;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, v, w;
  logic [25:0] in;
  logic [31:0] seed;
  int bad_count, checks_done, tmo;
  logic clkrun_n_o, clkrun_oe_o, pci_out_float_o, pci_clk_gate_o, core_reset_o, cclkrun_oe_o, card_clk_en_o;
  logic card_hiz_o, card_reset_o, ring_wake_output_o, multifunction_terminal_two_o, multifunction_terminal_four_o;
  logic card16_busy_i, card_master_busy_i, card_posted_i, int_pending_i, serial_res_busy_i, serial_master_busy_i;
  logic serial_posted_i, interrogation_i, serial_not_idle_i, fifo_data_i, tp_active_i, card_ireq_i, card_cint_i;
  logic card_stschg_i, card_wake_event_i, card_req_i, card_ring_i, card_powered_i, card16_active_i, pme_event_i;
  logic card_bus_active_i, bus_grant_i, host_bus_reset_i, global_reset_input_i, suspend_i, cclkrun_n_i, card_clkrun_n;
  assign {card_clkrun_n, suspend_i, global_reset_input_i, host_bus_reset_i, bus_grant_i, pme_event_i,
    card_bus_active_i, card16_active_i, card_powered_i, card_ring_i, card_req_i, card_wake_event_i, card_stschg_i,
    card_cint_i, card_ireq_i, tp_active_i, fifo_data_i, serial_not_idle_i, interrogation_i, serial_posted_i,
    serial_master_busy_i, serial_res_busy_i, int_pending_i, card_posted_i, card_master_busy_i, card16_busy_i} = in;
  // Card clock-run line is wired: either side may pull it low
  assign cclkrun_n_i = card_clkrun_n & !cclkrun_oe_o;
  bus_clock_model partner (.stop_req_i(stop_req), .dev_oe_i(clkrun_oe_o), .dev_n_i(clkrun_n_o),
    .pci_clk_o(pci_clk_i), .clkrun_n_o(clkrun_n_i), .running_o(running));
  pci_clock_run_power_manager dut (.*);
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = !sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    tmo++;
    if (tmo == 30000) begin
      bad_count++;
      final_report();
    end
  end
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd
  function automatic logic [15:0] rmask(input logic [3:0] a);
    logic [15:0] m [8];
    m = '{16'h000F, 16'h0001, 16'h0080, 16'h0080, 16'h0001, 16'h0001, 16'h0080, 16'h0100};
    return (a < 4'h8) ? m[a[2:0]] : 16'h0000;
  endfunction : rmask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task stopcase(input logic e);
    stop_req <= 1'b1;
    cyc(400);
    rd(4'h8);
    chk("clock stopped", e, v[6]);
    chk("clock running", !e, running);
  endtask : stopcase
  task final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // ******
  // Scenarios
  // ******
  initial begin
    {srst_i, reg_wr_i, reg_rd_i, stop_req, reg_addr_i, reg_wdata_i} = {4'b1000, 20'h00000};
    in = 26'h2000000;
    seed = 32'h152FCEC7;
    cyc(10);
    srst_i <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      if (a == 8) continue;
      rd(a[3:0]);
      chk("reset value", 16'h0000, v);
      w = rnd();
      wr(a[3:0], w);
      rd(a[3:0]);
      chk("readback", w & rmask(a[3:0]), v);
      wr(a[3:0], 16'h0000);
    end
    $display("test registers done");
    cyc(30);
    wr(4'h0, 16'h0002);
    stopcase(1'b1);
    stop_req <= 1'b0;
    wr(4'h0, 16'h0006);
    cyc(60);
    chk("hold restart", 1'b1, running);
    wr(4'h0, 16'h0004);
    foreach (KEEP[i]) begin
      in[KEEP[i]] <= 1'b1;
      stopcase(1'b0);
      {in[KEEP[i]], stop_req} <= 2'b00;
      cyc(40);
    end
    for (int j = 0; j < 2; j++) begin
      wr(j[3:0], j ? 16'h0001 : 16'h0006);
      stopcase(1'b0);
      wr(j[3:0], j ? 16'h0000 : 16'h0004);
      stop_req <= 1'b0;
      cyc(40);
    end
    stopcase(1'b1);
    chk("card clock", 1'b0, card_clk_en_o);
    foreach (WAKE[i]) begin
      {in[WAKE[i]], stop_req} <= 2'b10;
      cyc(60);
      chk("restart", 1'b1, running);
      in[WAKE[i]] <= 1'b0;
      stopcase(1'b1);
    end
    {in[25], stop_req} <= 2'b00;
    cyc(60);
    chk("card clock start", 1'b1, running);
    chk("card clock on", 1'b1, card_clk_en_o);
    in[25] <= 1'b1;
    $display("test clock run done");
    wr(4'h2, 16'h0080);
    cyc(3);
    chk("hiz", 1'b1, card_hiz_o);
    chk("card reset", 1'b1, card_reset_o);
    cyc(21);
    chk("card reset end", 1'b0, card_reset_o);
    wr(4'h2, 16'h0000);
    wr(4'h4, 16'h0001);
    cyc(5);
    chk("auto hiz", 1'b1, card_hiz_o);
    chk("no reset", 1'b0, card_reset_o);
    in[18] <= 1'b1;
    cyc(5);
    chk("active", 1'b0, card_hiz_o);
    $display("test card power done");
    for (int j = 0; j < 4; j++) begin
      in[24] <= (j < 2); // grant stays low: the bus is never parked here
      wr(4'h5, 16'h0001);
      in[22 + j % 2] <= 1'b1;
      cyc(6);
      chk("core reset", j >= 2, core_reset_o);
      chk("float", j < 2, pci_out_float_o);
      chk("clock gate", j < 2, pci_clk_gate_o);
      in[22 + j % 2] <= 1'b0;
      cyc(6);
      rd(4'h5);
      chk("kept", j < 2, v);
    end
    {in[24], in[21]} <= 2'b11;
    cyc(6);
    chk("grant float", 1'b0, pci_out_float_o);
    chk("grant gate", 1'b0, pci_clk_gate_o);
    in[21] <= 1'b0;
    $display("test suspend done");
    wr(4'h0, 16'h0000);
    wr(4'h6, 16'h0080);
    wr(4'h3, 16'h0080);
    {in[17], in[16]} <= 2'b11;
    cyc(6);
    chk("ring", 1'b1, ring_wake_output_o);
    in[17] <= 1'b0;
    cyc(6);
    chk("unpowered ring", 1'b0, ring_wake_output_o);
    {in[17], in[16], in[20]} <= 3'b101;
    wr(4'h7, 16'h0100);
    cyc(6);
    chk("wake hidden", 1'b0, ring_wake_output_o);
    wr(4'h6, 16'h0000);
    cyc(6);
    chk("wake alone", 1'b1, ring_wake_output_o);
    wr(4'h0, 16'h0001); // both functions in use: separate routing
    wr(4'h6, 16'h0080);
    in[16] <= 1'b1;
    cyc(6);
    chk("terminal two", 1'b1, multifunction_terminal_two_o);
    chk("shared wake", 1'b1, ring_wake_output_o);
    wr(4'h0, 16'h0009);
    cyc(6);
    chk("terminal four", 1'b1, multifunction_terminal_four_o);
    {in[16], in[14]} <= 2'b01;
    wr(4'h5, 16'h0000);
    cyc(6);
    chk("masked wake", 1'b0, multifunction_terminal_four_o);
    wr(4'h5, 16'h0001);
    cyc(6);
    chk("card wake", 1'b1, multifunction_terminal_four_o);
    $display("test ring done");
    final_report();
  end
endmodule : tb
